//--- design/bcd_dma.sv
// Memory copy and Internet checksum DMA engine with APB register slave
`default_nettype none
module bcd_dma #(
  parameter int APB_AW = 8  // APB address width
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic      [14:0]       mem_addr,
  output logic      [15:0]       mem_wdata,
  output logic      [1:0]        mem_be,
  input  wire logic              mem_gnt,
  input  wire logic [15:0]       mem_rdata,
  output logic                   dma_busy,
  output logic                   dma_done
);
  import bcd_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (APB_AW < 6 || APB_AW > 16)
  begin : g_bad_aw
    $error("APB_AW must lie between 6 and 16");
  end

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    bcd_state_t  st;       // Engine sequence
    logic        busy;     // dma_start_busy
    logic        copy;     // copy_select
    logic        seed;     // seed_select
    logic        nocs;     // no_checksum
    logic [15:0] src;      // source_pointer
    logic [15:0] dst;      // destination_pointer
    logic [15:0] len;      // byte_length
    logic [15:0] csum;     // checksum_result
    logic [15:0] rxst;     // receive_buffer_start
    logic [15:0] udast;    // user_area_start
    logic [15:0] udand;    // user_area_end
    logic [15:0] cur_src;  // Working source address
    logic [15:0] cur_dst;  // Working destination address
    logic [15:0] rem;      // Bytes still to move
    logic        par;      // Odd byte position in the sum
    logic        two;      // Current chunk holds two bytes
    logic        rd_ok;    // Current read address is served
    logic        fault;    // A pointer left the served areas
    logic        done;     // Completion pulse
    logic        mem_req;  // Memory request
    logic        mem_we;   // Memory write
    logic [14:0] mem_addr; // Memory word address
    logic [15:0] mem_wd;   // Memory write data
    logic [1:0]  mem_be;   // Memory byte lanes
    logic [31:0] prdata;   // APB read data
    logic        pready;   // APB ready
    logic        pslverr;  // APB error
  } bcd_st_t;

  bcd_st_t     s_r;        // Registered state
  bcd_st_t     s_nxt;      // Next state
  logic        go_rd;      // Set up the next source read
  logic        cs_load;    // Seed the accumulator
  logic        cs_add;     // Add one word
  logic [15:0] cs_word;    // Positioned word for the sum
  logic [15:0] cs_seed;    // Start value of the sum
  logic [15:0] cs_sum;     // Current sum
  logic [15:0] rd_word;    // Read data, zero if unserved
  logic [7:0]  b_first;    // Earlier byte of the chunk
  logic [7:0]  b_second;   // Later byte of the chunk
  logic [31:0] reg_rd;     // APB read mux
  logic        reg_hit;    // APB address maps a register
  logic        apb_setup;  // APB setup cycle
  logic        apb_wr;     // APB write takes effect

  // ----------------------------------------
  // Address helpers
  // ----------------------------------------

  // Next byte address with wrap; user area checked first
  function automatic logic [15:0] nxt_addr(
    input logic [15:0] a,
    input logic [15:0] ud_st,
    input logic [15:0] ud_nd,
    input logic [15:0] rx_st
  );
    logic [15:0] r;
    r = a + 16'h0001;
    if (a == ud_nd)
      r = ud_st;
    else if (a == rx_st - 16'h0001)
      r = ZERO16;
    else if (a == SRAM_LAST)
      r = rx_st;
    return r;
  endfunction

  // Served areas; everything else, register space included, is refused
  function automatic logic addr_ok(input logic [15:0] a);
    return (a <= SRAM_LAST) ||
           (a >= CRYPTO_FIRST && a <= CRYPTO_LAST);
  endfunction

  // ----------------------------------------
  // Checksum accumulator
  // ----------------------------------------
  assign cs_seed = s_r.seed ? ~s_r.csum : ZERO16;

  bcd_csum u_csum (
    .clk   (clk),
    .reset (reset),
    .load  (cs_load),
    .seed  (cs_seed),
    .add   (cs_add),
    .word  (cs_word),
    .sum   (cs_sum)
  );

  // ----------------------------------------
  // Read data byte selection
  // ----------------------------------------

  // Even byte address sits in lane 0, odd in lane 1
  always_comb
  begin
    rd_word  = s_r.rd_ok ? mem_rdata : ZERO16;
    b_first  = s_r.cur_src[0] ? rd_word[15:8] : rd_word[7:0];
    b_second = rd_word[15:8];
  end

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  always_comb
  begin
    reg_rd  = 32'h0000_0000;
    reg_hit = 1'b1;
    unique case (8'(paddr))
      OFS_CTRL:
      begin
        reg_rd[BIT_START] = s_r.busy;
        reg_rd[BIT_COPY]  = s_r.copy;
        reg_rd[BIT_SEED]  = s_r.seed;
        reg_rd[BIT_NOCS]  = s_r.nocs;
      end
      OFS_SRC:   reg_rd[15:0] = s_r.src;
      OFS_DST:   reg_rd[15:0] = s_r.dst;
      OFS_LEN:   reg_rd[15:0] = s_r.len;
      OFS_CSUM:  reg_rd[15:0] = s_r.csum;
      OFS_RXST:  reg_rd[15:0] = s_r.rxst;
      OFS_UDAST: reg_rd[15:0] = s_r.udast;
      OFS_UDAND: reg_rd[15:0] = s_r.udand;
      OFS_STAT:
      begin
        reg_rd[BIT_BUSY]  = s_r.busy;
        reg_rd[BIT_FAULT] = s_r.fault;
      end
      default:   reg_hit = 1'b0;  // Unmapped: error answer
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  // Engine first, bus second, so a cancel overrides the engine step
  always_comb
  begin
    s_nxt   = s_r;
    s_nxt.done = 1'b0;
    go_rd   = 1'b0;
    cs_load = 1'b0;
    cs_add  = 1'b0;
    cs_word = ZERO16;
    apb_setup = psel && !penable && !s_r.pready;
    apb_wr    = psel && penable && s_r.pready && pwrite;

    unique case (s_r.st)
      ST_IDLE:
      begin
        s_nxt.mem_req = 1'b0;
      end
      // Latch operands and seed the sum
      ST_LOAD:
      begin
        cs_load       = 1'b1;
        s_nxt.cur_src = s_r.src;
        s_nxt.cur_dst = s_r.dst;
        s_nxt.rem     = s_r.len;
        s_nxt.par     = 1'b0;
        if (s_r.len == ZERO16)
          s_nxt.st = ST_FIN;
        else
          go_rd = 1'b1;
      end
      // Hold the read until the arbiter grants it
      ST_RD:
      begin
        if (!s_r.mem_req || mem_gnt)
        begin
          s_nxt.mem_req = 1'b0;
          s_nxt.st      = ST_RDATA;
        end
      end
      // Data is back: sum it, then write or fetch on
      ST_RDATA:
      begin
        if (!s_r.nocs)
        begin
          cs_add = 1'b1;
          // Earlier byte high at an even sum position, low at an odd one; a lone last byte gets a zero pad
          if (s_r.two)
            cs_word = s_r.par ? {b_second, b_first}
                              : {b_first, b_second};
          else
            cs_word = s_r.par ? {PAD_BYTE, b_first}
                              : {b_first, PAD_BYTE};
        end
        s_nxt.par = s_r.par ^ !s_r.two;
        s_nxt.cur_src = nxt_addr(s_r.cur_src, s_r.udast,
                                 s_r.udand, s_r.rxst);
        if (s_r.two)
          s_nxt.cur_src = nxt_addr(s_nxt.cur_src, s_r.udast,
                                   s_r.udand, s_r.rxst);
        s_nxt.rem = s_r.rem - (s_r.two ? 16'h0002 : 16'h0001);
        if (s_r.copy)
        begin
          // Byte lanes limit the write to the bytes read
          s_nxt.mem_we   = 1'b1;
          s_nxt.mem_addr = s_r.cur_dst[15:1];
          if (s_r.two)
          begin
            s_nxt.mem_be = 2'b11;
            s_nxt.mem_wd = {b_second, b_first};
          end
          else
          begin
            s_nxt.mem_be = s_r.cur_dst[0] ? 2'b10 : 2'b01;
            s_nxt.mem_wd = {b_first, b_first};
          end
          s_nxt.mem_req = addr_ok(s_r.cur_dst);
          if (!addr_ok(s_r.cur_dst))
            s_nxt.fault = 1'b1;
          s_nxt.st = ST_WR;
        end
        else if (s_nxt.rem == ZERO16)
          s_nxt.st = ST_FIN;
        else
          go_rd = 1'b1;
      end
      // Hold the write until granted; each read precedes its write
      ST_WR:
      begin
        if (!s_r.mem_req || mem_gnt)
        begin
          s_nxt.mem_req = 1'b0;
          s_nxt.mem_we  = 1'b0;
          s_nxt.cur_dst = nxt_addr(s_r.cur_dst, s_r.udast,
                                   s_r.udand, s_r.rxst);
          if (s_r.two)
            s_nxt.cur_dst = nxt_addr(s_nxt.cur_dst, s_r.udast,
                                     s_r.udand, s_r.rxst);
          if (s_r.rem == ZERO16)
            s_nxt.st = ST_FIN;
          else
            go_rd = 1'b1;
        end
      end
      // Publish the result and drop the start bit
      ST_FIN:
      begin
        if (!s_r.nocs)
          s_nxt.csum = ~cs_sum;
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.st   = ST_IDLE;
      end
      default:
      begin
        s_nxt.st      = ST_IDLE;
        s_nxt.busy    = 1'b0;
        s_nxt.mem_req = 1'b0;
      end
    endcase

    // Source read setup; a chunk takes two bytes only when the source,
    // and when copying the destination, is even and no wrap falls between them
    if (go_rd)
    begin
      s_nxt.st = ST_RD;
      s_nxt.two = !s_nxt.cur_src[0] && (s_nxt.rem > 16'h0001) &&
                  (nxt_addr(s_nxt.cur_src, s_r.udast, s_r.udand,
                            s_r.rxst) == s_nxt.cur_src + 16'h0001) &&
                  (!s_r.copy || (!s_nxt.cur_dst[0] &&
                   (nxt_addr(s_nxt.cur_dst, s_r.udast, s_r.udand,
                             s_r.rxst) == s_nxt.cur_dst + 16'h0001)));
      s_nxt.mem_addr = s_nxt.cur_src[15:1];
      s_nxt.mem_we   = 1'b0;
      s_nxt.mem_be   = 2'b11;
      s_nxt.rd_ok    = addr_ok(s_nxt.cur_src);
      s_nxt.mem_req  = addr_ok(s_nxt.cur_src);
      if (!addr_ok(s_nxt.cur_src))
        s_nxt.fault = 1'b1;
    end

    // APB: answer prepared in setup, ready in the access cycle
    s_nxt.pready = apb_setup;
    s_nxt.pslverr = apb_setup && !reg_hit;
    if (apb_setup)
      s_nxt.prdata = reg_rd;

    // APB write takes effect at the access edge
    if (apb_wr && reg_hit)
    begin
      unique case (8'(paddr))
        OFS_CTRL:
        begin
          s_nxt.copy = pwdata[BIT_COPY];
          s_nxt.seed = pwdata[BIT_SEED];
          s_nxt.nocs = pwdata[BIT_NOCS];
          if (!s_r.busy && pwdata[BIT_START])
          begin
            s_nxt.busy  = 1'b1;
            s_nxt.fault = 1'b0;
            s_nxt.st    = ST_LOAD;
          end
          else if (s_r.busy && !pwdata[BIT_START])
          begin
            // Cancel: no completion; result untouched except in ST_FIN, whose csum write stands
            s_nxt.busy    = 1'b0;
            s_nxt.done    = 1'b0;
            s_nxt.mem_req = 1'b0;
            s_nxt.mem_we  = 1'b0;
            s_nxt.st      = ST_IDLE;
          end
        end
        OFS_SRC:   s_nxt.src   = pwdata[15:0];
        OFS_DST:   s_nxt.dst   = pwdata[15:0];
        OFS_LEN:   s_nxt.len   = pwdata[15:0];
        OFS_CSUM:  s_nxt.csum  = pwdata[15:0];
        OFS_RXST:  s_nxt.rxst  = pwdata[15:0];
        OFS_UDAST: s_nxt.udast = pwdata[15:0];
        OFS_UDAND: s_nxt.udand = pwdata[15:0];
        default:   s_nxt.fault = s_nxt.fault;  // Status is read-only
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r       <= '0;
      s_r.st    <= ST_IDLE;
      s_r.rxst  <= RST_RXST;
      s_r.udast <= RST_UDA;
      s_r.udand <= RST_UDA;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------
  assign prdata    = s_r.prdata;
  assign pready    = s_r.pready;
  assign pslverr   = s_r.pslverr;
  assign mem_req   = s_r.mem_req;
  assign mem_we    = s_r.mem_we;
  assign mem_addr  = s_r.mem_addr;
  assign mem_wdata = s_r.mem_wd;
  assign mem_be    = s_r.mem_be;
  assign dma_busy  = s_r.busy;
  assign dma_done  = s_r.done;

endmodule // bcd_dma
`default_nettype wire

//--- design/bcd_pkg.sv
// Package: register map, bit positions and constants of the copy/checksum DMA
`default_nettype none
package bcd_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;  // first_control_register
  localparam logic [7:0] OFS_SRC   = 8'h04;  // source_pointer
  localparam logic [7:0] OFS_DST   = 8'h08;  // destination_pointer
  localparam logic [7:0] OFS_LEN   = 8'h0C;  // byte_length
  localparam logic [7:0] OFS_CSUM  = 8'h10;  // checksum_result
  localparam logic [7:0] OFS_RXST  = 8'h14;  // receive_buffer_start
  localparam logic [7:0] OFS_UDAST = 8'h18;  // user_area_start
  localparam logic [7:0] OFS_UDAND = 8'h1C;  // user_area_end
  localparam logic [7:0] OFS_STAT  = 8'h20;  // engine status

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_START = 5;  // dma_start_busy
  localparam int BIT_COPY  = 4;  // copy_select
  localparam int BIT_SEED  = 3;  // seed_select
  localparam int BIT_NOCS  = 2;  // no_checksum
  localparam int BIT_BUSY  = 0;  // Status: engine active
  localparam int BIT_FAULT = 1;  // Status: pointer left the served areas

  // ----------------------------------------
  // Memory areas and reset values
  // ----------------------------------------
  localparam logic [15:0] SRAM_LAST    = 16'h5FFF;
  localparam logic [15:0] CRYPTO_FIRST = 16'h7800;
  localparam logic [15:0] CRYPTO_LAST  = 16'h7C4F;
  localparam logic [15:0] RST_RXST     = 16'h3000;
  localparam logic [15:0] RST_UDA      = 16'h6000;  // Outside SRAM: no user wrap
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [7:0]  PAD_BYTE     = 8'h00;

  // Engine sequence
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_RD, ST_RDATA, ST_WR, ST_FIN
  } bcd_state_t;

endpackage
`default_nettype wire

//--- design/bcd_csum.sv
// One's-complement 16-bit accumulator with end-around carry
`default_nettype none
module bcd_csum (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        load,
  input  wire logic [15:0] seed,
  input  wire logic        add,
  input  wire logic [15:0] word,
  output logic      [15:0] sum
);
  import bcd_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] acc;  // Running sum
  } bcd_csum_st_t;

  bcd_csum_st_t s_r;    // Registered state
  bcd_csum_st_t s_nxt;  // Next state
  logic [16:0]  raw;    // Sum with carry out

  // Add one positioned word, folding the carry back in;
  // the fold cannot carry again, so one adder stage suffices
  always_comb
  begin
    s_nxt = s_r;
    raw   = {1'b0, s_r.acc} + {1'b0, word};
    if (load)
      s_nxt.acc = seed;
    else if (add)
      s_nxt.acc = raw[15:0] + {15'h0000, raw[16]};
  end

  // Register the state
  always_ff @(posedge clk)
  begin
    if (reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign sum = s_r.acc;

endmodule // bcd_csum
`default_nettype wire

//--- testbench/bcd_dma_assertions.sv
// Checker: port-level timing properties of the copy and checksum engine
`default_nettype none
module bcd_dma_assertions (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [14:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [1:0]  mem_be,
  input wire logic        mem_gnt,
  input wire logic        dma_busy,
  input wire logic        dma_done
);
  timeunit 1ns / 1ps;
  // ------------------------------------------------------------
  // One domain, so clock and reset are given once
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no register answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("register answer held too long");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer without ready or with data");

  // ------------------------------------------------------------
  // Memory port: a refused access is held until granted; only a cancel drops it
  // ------------------------------------------------------------
  a_req_hold: assert property (mem_req && !mem_gnt |=>
    mem_req && $stable({mem_we, mem_addr, mem_wdata, mem_be}))
    else $error("memory request changed before grant");
  a_addr_served: assert property (mem_req |-> mem_addr <= 15'h2FFF ||
    (mem_addr >= 15'h3C00 && mem_addr <= 15'h3E27))
    else $error("memory request outside served areas");
  a_idle_quiet: assert property (!dma_busy && !$past(dma_busy) |-> !mem_req)
    else $error("memory request while idle");
  a_word_pace: assert property (mem_req && mem_gnt |->
    ##[1:3] (mem_req || !dma_busy))
    else $error("engine paused between words");

  // ------------------------------------------------------------
  // Start and completion
  // ------------------------------------------------------------
  a_start_moves: assert property ($rose(dma_busy) |-> ##[1:4] (mem_req || !dma_busy))
    else $error("engine slow to begin after start");
  a_done_fall: assert property (dma_done |-> !dma_busy && $past(dma_busy))
    else $error("completion pulse without busy falling");
  a_done_pulse: assert property (dma_done |=> !dma_done)
    else $error("completion pulse longer than one cycle");
endmodule // bcd_dma_assertions

bind bcd_dma bcd_dma_assertions chk_i (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_gnt(mem_gnt),
  .dma_busy(dma_busy), .dma_done(dma_done)
);
`default_nettype wire

//--- testbench/bcd_mem_model.sv
// Partner model: word-wide packet memory with an arbiter that can stall
`default_nettype none
module bcd_mem_model (
  input wire logic        clk,
  input wire logic        slow,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [14:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [1:0]  mem_be,
  output logic            mem_gnt,
  output logic     [15:0] mem_rdata
);
  timeunit 1ns / 1ps;
  // ------------------------------------------------------------
  // Storage and contention pacing
  // ------------------------------------------------------------
  logic [15:0] m [0:32767];  // Even byte in low lane
  logic [1:0]  cnt = 2'h0;   // Free-running contention phase

  // Another user holds the memory every other cycle when slow
  assign mem_gnt = !slow || cnt[0];

  // ------------------------------------------------------------
  // Access at the granting edge; data shows the next cycle only
  // ------------------------------------------------------------
  initial mem_rdata = 16'h0000;
  always @(posedge clk)
  begin
    cnt <= cnt + 2'h1;
    if (mem_req && mem_gnt && mem_we)
    begin
      // Lanes written one by one so a lone byte leaves its twin alone
      if (mem_be[0]) m[mem_addr][7:0] <= mem_wdata[7:0];
      if (mem_be[1]) m[mem_addr][15:8] <= mem_wdata[15:8];
    end
    // Outside a read answer the bus toggles, so stale data never matches
    mem_rdata <= (mem_req && mem_gnt && !mem_we) ? m[mem_addr] : ~mem_rdata;
  end
endmodule // bcd_mem_model
`default_nettype wire

//--- testbench/bcd_tb.sv
// Testbench: register-driven copy, checksum, wrap and cancel scenarios
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bcd_pkg::*;
  // ------------------------------------------------------------
  // Signals and bench state
  // ------------------------------------------------------------
  logic        clk, reset, psel, penable, pwrite, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, mem_req, mem_we, mem_gnt, dma_busy, dma_done;
  logic [14:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [1:0]  mem_be;
  int          n_fail, checks, n_done, cyc;
  logic [32:0] q [$];          // Expected read answers, oldest first
  logic [31:0] rs;             // Random generator state
  logic [15:0] csr, uds, ude, rxs;  // Bench copy of result and wrap points

  always #4 clk = ~clk;

  bcd_dma bcd_dma_i (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_gnt(mem_gnt), .mem_rdata(mem_rdata), .dma_busy(dma_busy),
    .dma_done(dma_done));
  bcd_mem_model bcd_mem_model_i (.clk(clk), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_be(mem_be), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] rb(input logic [15:0] a);
    return a[0] ? bcd_mem_model_i.m[a[15:1]][15:8] : bcd_mem_model_i.m[a[15:1]][7:0];
  endfunction
  // Next byte address after the wrap checks, user area first
  function automatic logic [15:0] nx(input logic [15:0] a);
    if (a == ude) return uds;
    if (a == rxs - 16'h0001) return 16'h0000;
    if (a == SRAM_LAST) return rxs;
    return a + 16'h0001;
  endfunction
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bus cycle: setup, then access held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // One operation: expectations from a snapshot taken before the start
  task automatic op(input logic [5:0] c, input logic [15:0] s, input logic [15:0] d,
                    input int n);
    logic [7:0]  b [$];
    logic [7:0]  o [$];
    logic [15:0] a, acc;
    logic [16:0] t;
    int          k, d0;
    acc = c[3] ? ~csr : 16'h0000;
    a = s;
    for (k = 0; k < n; k++)
    begin
      // Unserved addresses read as zero
      b.push_back((a <= SRAM_LAST || (a >= CRYPTO_FIRST && a <= CRYPTO_LAST)) ? rb(a) : 8'h00);
      a = nx(a);
    end
    a = d;
    for (k = 0; k <= n; k++)
    begin
      o.push_back(rb(a));
      a = nx(a);
    end
    for (k = 0; k < n; k += 2)
    begin
      t = acc + {b[k], (k + 1 < n) ? b[k + 1] : PAD_BYTE};
      acc = t[15:0] + {15'h0000, t[16]};
    end
    if (!c[2]) csr = ~acc;
    d0 = n_done;
    apb(1'b1, OFS_SRC, {16'h0000, s});
    apb(1'b1, OFS_DST, {16'h0000, d});
    apb(1'b1, OFS_LEN, 32'(n));
    apb(1'b1, OFS_CTRL, {26'h000_0000, c});
    cyc = 0;
    do
    begin
      @(posedge clk);
      cyc++;
    end while (dma_busy !== 1'b0 && cyc < 5000);
    @(posedge clk);
    chk(33'(n_done - d0), 33'h0_0000_0001);
    rd(OFS_CTRL, {28'h000_0000, c[4:0]});
    rd(OFS_CSUM, {17'h0_0000, csr});
    a = d;
    for (k = 0; k <= n; k++)
    begin
      chk({25'h000_0000, rb(a)}, {25'h000_0000, (c[4] && k < n) ? b[k] : o[k]});
      a = nx(a);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Read answers are compared as they appear, in issue order
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, q.pop_front());
    if (dma_done === 1'b1)
      n_done++;
  end

  // Hang guard: the whole run needs a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test;
  end

  // ------------------------------------------------------------
  // Main sequence; software only starts when the engine is idle
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; slow = 1'b0;
    rs = 32'h0001_6047;
    csr = 16'h0000; uds = RST_UDA; ude = RST_UDA; rxs = RST_RXST;
    for (int i = 0; i < 32768; i++)
    begin
      rs = lfsr(rs);
      bcd_mem_model_i.m[i] = rs[15:0];
    end
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_CTRL, 33'h0_0000_0000);
    rd(OFS_RXST, 33'h0_0000_3000);
    rd(OFS_UDAST, 33'h0_0000_6000);
    rd(OFS_UDAND, 33'h0_0000_6000);
    rd(OFS_STAT, 33'h0_0000_0000);
    rd(8'h24, 33'h1_0000_0000);
    rd(8'h05, 33'h1_0000_0000);
    apb(1'b1, OFS_STAT, 32'h0000_0003);
    rd(OFS_STAT, 33'h0_0000_0000);
    $display("test reset_and_map done");
    bcd_mem_model_i.m[16'h0080] = 16'hAB89;
    bcd_mem_model_i.m[16'h0081][7:0] = 8'hCD;
    op(6'h20, 16'h0100, 16'h0200, 3);
    rd(OFS_CSUM, 33'h0_0000_A953);
    op(6'h28, 16'h0300, 16'h0000, 6);
    op(6'h30, 16'h0001, 16'h0000, 65);
    op(6'h34, 16'h0002, 16'h0001, 9);
    op(6'h30, 16'h0400, 16'h7801, 10);
    op(6'h20, 16'h7800, 16'h0000, 8);
    op(6'h30, 16'h0500, 16'h0600, 0);
    chk(33'(cyc <= 4), 33'h0_0000_0001);
    op(6'h28, 16'h0500, 16'h0600, 0);
    $display("test copy_and_checksum done");
    op(6'h20, 16'h6000, 16'h0000, 1);
    rd(OFS_STAT, 33'h0_0000_0002);
    for (int i = 0; i < 4; i++)
    begin
      uds = (i[1:0] == 2'h1 || i[1:0] == 2'h2) ? RST_UDA : 16'h1000;
      ude = (i == 0) ? 16'h1003 : ((i == 3) ? SRAM_LAST : RST_UDA);
      apb(1'b1, OFS_UDAST, {16'h0000, uds});
      apb(1'b1, OFS_UDAND, {16'h0000, ude});
      op(6'h20, (i == 0) ? 16'h1002 : ((i == 2) ? 16'h2FFF : 16'h5FFE), 16'h0000,
         6 - i);
    end
    rd(OFS_STAT, 33'h0_0000_0000);
    $display("test wrap_and_fault done");
    for (int i = 0; i < 6; i++)
    begin
      slow <= i[0];
      op((i < 2) ? 6'h20 : 6'h30, (i < 4) ? 16'h0800 : 16'h0A01, 16'h2000, 64);
      chk(33'(cyc <= ((i < 2) ? 80 : ((i < 4) ? 160 : 240)) * (1 + i % 2)),
          33'h0_0000_0001);
    end
    $display("test throughput done");
    apb(1'b1, OFS_SRC, 32'h0000_0800);
    apb(1'b1, OFS_DST, 32'h0000_2400);
    apb(1'b1, OFS_LEN, 32'h0000_00C8);
    cyc = n_done;
    apb(1'b1, OFS_CTRL, 32'h0000_0030);
    repeat (10) @(posedge clk);
    apb(1'b1, OFS_CTRL, 32'h0000_0010);
    repeat (3) @(posedge clk);
    chk({32'h0000_0000, dma_busy}, 33'h0_0000_0000);
    chk(33'(n_done - cyc), 33'h0_0000_0000);
    rd(OFS_CSUM, {17'h0_0000, csr});
    slow <= 1'b0;
    $display("test cancel done");
    for (int i = 0; i < 6; i++)
    begin
      rs = lfsr(rs);
      op({1'b1, rs[26], rs[27], rs[28], 2'h0}, 16'h0800 + {6'h00, rs[9:0]},
         16'h2000 + {6'h00, rs[19:10]}, int'(rs[25:20]));
    end
    $display("test random_ops done");
    finish_test;
  end
endmodule // tb
`default_nettype wire
